// [hw/eapi_irl_filter.sv]
/*
 * two-sample noise canceller for the active-low encoded level inputs.
 * assumes raw_b is already synchronised to clock_in.
 */
`timescale 1ns/100ps
`include "eapi_map.svh"

module eapi_irl_filter (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// filter link
	eapi_flt_if.filt flt
);
	import eapi_pkg::*;

	eapi_flt_s st_q;
	eapi_flt_s st_d;

	always_comb begin
		st_d = st_q;
		if (flt.sample) begin
			st_d.prev_b = flt.raw_b; // RQ6
			// all zeros means level 15, all ones means no request
			if (flt.raw_b == st_q.prev_b) begin
				st_d.lvl = ~flt.raw_b; // RQ5 RQ6
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '{prev_b: `EAPI_RST_IRL_B, lvl: 4'h0};
		end else begin
			st_q <= st_d;
		end
	end

	assign flt.level = st_q.lvl;
endmodule

// [hw/eapi_top.sv]
/*
 * interrupt source prioritizer: eight request lines, encoded level
 * inputs, two pin groups and six on-chip peripheral requests, ranked
 * into one request with level and event code toward the cpu.
 * assumes pins are asynchronous, peripheral requests and cpu accept
 * come from clock_in logic, and rtc_tick_in is a slow rtc clock level.
 */
// Local design decisions: the address map and the plain strobed port.
// Overview of operation
// [RQ1] with level hold on, a detected line request is latched and kept
// [RQ2] latched line cleared after negation by any accept or mask set
// [RQ3] software clears the latch before reopening acceptance
// [RQ4] on accept, threshold takes accepted level if auto update set
// [RQ5] encoded inputs active low: zeros mean 15, ones mean none
// [RQ6] encoded level recognised after two equal consecutive samples
// [RQ7] in standby the canceller samples only on rtc clock ticks
// [RQ8] source holds encoded level until handling begins, may raise it
// [RQ9] accepting an encoded-level request leaves the threshold alone
// [RQ10] pin groups a and b level sensed, priorities from reg d
// [RQ11] pin group source holds its request until handling starts
// [RQ12] each source has its own code, stored on accept
// [RQ13] four-bit programmable priorities, reset to level 0
// [RQ14] equal priorities resolved by a fixed default order
// [RQ15] software edits priorities only while the gate bit is set
// [RQ16] software edits peripheral flags only while blocked or masked
// [RQ17] accept with nothing pending stores event code 0
// [RQ18] encoded value k gives code 0x200 plus 0x20 k, level 15 minus k
// [RQ19] lines 0 to 7 give codes 0x600 to 0x6E0, priorities msb first
// [RQ20] timers give 0x400, 0x420, 0x440 with reg a nibbles
// [RQ21] rtc alarm, periodic, carry share reg a low nibble, alarm first
// [RQ22] pin group a gives 0x4E0, group b gives 0x500
// [RQ23] priority level 0 masks a source entirely
// [RQ24] with level hold off, level requests are not latched
// [RQ25] request forwarded only when level exceeds the threshold
// [RQ26] best source recomputed every cycle, level and code together
`timescale 1ns/100ps
`include "eapi_map.svh"

module eapi_top #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// external pins
	input wire logic [7:0] ext_line_in,
	input wire logic [3:0] encoded_level_inputs_b_in,
	input wire logic [7:0] pin_group_a_inputs_in,
	input wire logic [3:0] pin_group_b_inputs_in,
	// peripheral requests
	input wire logic [2:0] timer_underflow_in,
	input wire logic rtc_alarm_source_in,
	input wire logic rtc_periodic_source_in,
	input wire logic rtc_carry_source_in,
	// standby and rtc clock
	input wire logic standby_in,
	input wire logic rtc_tick_in,
	// cpu side
	input wire logic cpu_accept_in,
	output logic irq_req_out,
	output eapi_pkg::eapi_lvl_t irq_level_out,
	output eapi_pkg::eapi_code_t irq_code_out,
	output eapi_pkg::eapi_code_t interrupt_event_code_reg_out,
	output eapi_pkg::eapi_lvl_t cpu_level_threshold_out
);
	import eapi_pkg::*;

	localparam int NSRC = 17;

	eapi_state_s s_q;
	eapi_state_s s_d;
	eapi_flt_if flt_if();

	// ----------------------------------------------------------------
	// encoded-level noise canceller
	// ----------------------------------------------------------------
	eapi_irl_filter u_filter (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.flt(flt_if.filt)
	);

	// the peripheral clock stops in standby, so only rtc ticks sample;
	// without a running rtc clock nothing is ever recognised there
	assign flt_if.raw_b = s_q.il_s2;
	assign flt_if.sample = !standby_in || (s_q.tk_s2 && !s_q.tk_s3); // RQ7

	// ----------------------------------------------------------------
	// source table, default order: index 0 ranks highest
	// ----------------------------------------------------------------
	eapi_lvl_t src_lvl [NSRC];
	eapi_code_t src_code [NSRC];
	logic [NSRC-1:0] src_pend;
	logic [7:0] line_req;
	logic [7:0] line_det;
	logic [7:0] line_clr;
	eapi_lvl_t line_lvl [8];
	eapi_code_t line_code [8];

	always_comb begin
		eapi_lvl_t k;
		k = ~flt_if.level;
		src_lvl[0] = flt_if.level; // RQ5
		src_code[0] = `EAPI_EVT_IRL_BASE +
			12'(`EAPI_EVT_STEP * k); // RQ18
		src_pend[0] = (flt_if.level != 4'h0);
		for (int i = 0; i < 8; i++) begin
			src_lvl[1+i] = line_lvl[i]; // RQ19
			src_code[1+i] = line_code[i]; // RQ19
			// a masked line still latches, it only stops requesting
			src_pend[1+i] = line_req[i] && !s_q.mask[i];
		end
		src_lvl[9] = s_q.pri_a[`EAPI_PRA_TMR0_MSB -: 4]; // RQ20
		src_lvl[10] = s_q.pri_a[`EAPI_PRA_TMR1_MSB -: 4];
		src_lvl[11] = s_q.pri_a[`EAPI_PRA_TMR2_MSB -: 4];
		src_code[9] = `EAPI_EVT_TMR0; // RQ20
		src_code[10] = `EAPI_EVT_TMR1;
		src_code[11] = `EAPI_EVT_TMR2;
		src_pend[11:9] = timer_underflow_in;
		// rtc sources share one nibble, alarm before periodic before carry
		src_lvl[12] = s_q.pri_a[`EAPI_PRA_RTC_MSB -: 4]; // RQ21
		src_lvl[13] = s_q.pri_a[`EAPI_PRA_RTC_MSB -: 4];
		src_lvl[14] = s_q.pri_a[`EAPI_PRA_RTC_MSB -: 4];
		src_code[12] = `EAPI_EVT_RTC_ALM; // RQ21
		src_code[13] = `EAPI_EVT_RTC_PER;
		src_code[14] = `EAPI_EVT_RTC_CRY;
		src_pend[12] = rtc_alarm_source_in;
		src_pend[13] = rtc_periodic_source_in;
		src_pend[14] = rtc_carry_source_in;
		src_lvl[15] = s_q.pri_d[`EAPI_PRD_PINA_MSB -: 4]; // RQ10
		src_lvl[16] = s_q.pri_d[`EAPI_PRD_PINB_MSB -: 4]; // RQ10
		src_code[15] = `EAPI_EVT_PINA; // RQ22
		src_code[16] = `EAPI_EVT_PINB; // RQ22
		src_pend[15] = |s_q.pa_s2; // RQ10
		src_pend[16] = |s_q.pb_s2; // RQ10
	end

	// ----------------------------------------------------------------
	// winner selection
	// ----------------------------------------------------------------
	eapi_lvl_t best_lvl;
	eapi_code_t best_code;
	logic best_irl;

	always_comb begin
		best_lvl = 4'h0;
		best_code = `EAPI_EVT_NONE;
		best_irl = 1'b0;
		// strictly greater keeps the earlier source on ties, and level
		// zero can never beat the starting value
		for (int i = 0; i < NSRC; i++) begin
			if (src_pend[i] && src_lvl[i] > best_lvl) begin // RQ14 RQ23
				best_lvl = src_lvl[i];
				best_code = src_code[i];
				best_irl = (i == 0);
			end
		end
	end

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	logic wr_cfg;
	logic wr_lpri;
	logic wr_pa;
	logic wr_pd;
	logic wr_mset;
	logic wr_mclr;
	logic wr_thr;
	logic [31:0] rd_val;

	always_comb begin
		wr_cfg = reg_wr_in && reg_addr_in == `EAPI_OFS_CONFIG;
		wr_lpri = reg_wr_in && reg_addr_in == `EAPI_OFS_LINE_PRI;
		wr_pa = reg_wr_in && reg_addr_in == `EAPI_OFS_PRI_A;
		wr_pd = reg_wr_in && reg_addr_in == `EAPI_OFS_PRI_D;
		wr_mset = reg_wr_in && reg_addr_in == `EAPI_OFS_MASK_SET;
		wr_mclr = reg_wr_in && reg_addr_in == `EAPI_OFS_MASK_CLR;
		wr_thr = reg_wr_in && reg_addr_in == `EAPI_OFS_THRESHOLD;
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (reg_addr_in)
			`EAPI_OFS_CONFIG: begin
				rd_val[`EAPI_CFG_LHO_BIT] = s_q.cfg_lho;
				rd_val[`EAPI_CFG_ATU_BIT] = s_q.cfg_atu;
				rd_val[`EAPI_CFG_EDGE_LSB +: 8] = s_q.cfg_edge;
			end
			`EAPI_OFS_LINE_PRI: rd_val = s_q.pri_line;
			`EAPI_OFS_PRI_A: rd_val[15:0] = s_q.pri_a;
			`EAPI_OFS_PRI_D: rd_val[15:0] = s_q.pri_d;
			`EAPI_OFS_REQ_LATCH: rd_val[7:0] = s_q.latch;
			`EAPI_OFS_MASK_SET: rd_val[7:0] = s_q.mask;
			`EAPI_OFS_EVT_CODE: rd_val[11:0] = s_q.evt;
			`EAPI_OFS_THRESHOLD: rd_val[3:0] = s_q.thr;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// per-line request sensing
	// ----------------------------------------------------------------
	// a rising-edge line always goes through the latch, so a pulse
	// shorter than the handler entry is kept until the next accept of any source or a mask set write for its line
	for (genvar g = 0; g < 8; g++) begin : g_line
		assign line_det[g] = s_q.cfg_edge[g] ?
			(s_q.ln_s2[g] && !s_q.ln_s3[g]) :
			(s_q.ln_s2[g] && !s_q.cfg_lho); // RQ1 RQ24
		assign line_req[g] = (s_q.cfg_lho && !s_q.cfg_edge[g]) ?
			s_q.ln_s2[g] : s_q.latch[g]; // RQ1 RQ24
		// a line still high would only set its latch again at once
		assign line_clr[g] = !s_q.ln_s2[g] && (cpu_accept_in ||
			(wr_mset && reg_wdata_in[g])); // RQ2
		assign line_lvl[g] =
			s_q.pri_line[`EAPI_LINE_PRI_MSB-4*g -: 4]; // RQ19
		assign line_code[g] = `EAPI_EVT_LINE_BASE +
			12'(`EAPI_EVT_STEP * g); // RQ19
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// pin synchronisers
		s_d.ln_s1 = ext_line_in;
		s_d.ln_s2 = s_q.ln_s1;
		s_d.ln_s3 = s_q.ln_s2;
		s_d.pa_s1 = pin_group_a_inputs_in;
		s_d.pa_s2 = s_q.pa_s1;
		s_d.pb_s1 = pin_group_b_inputs_in;
		s_d.pb_s2 = s_q.pb_s1;
		s_d.il_s1 = encoded_level_inputs_b_in;
		s_d.il_s2 = s_q.il_s1;
		s_d.tk_s1 = rtc_tick_in;
		s_d.tk_s2 = s_q.tk_s1;
		s_d.tk_s3 = s_q.tk_s2;

		// software writes
		if (wr_cfg) begin
			s_d.cfg_lho = reg_wdata_in[`EAPI_CFG_LHO_BIT];
			s_d.cfg_atu = reg_wdata_in[`EAPI_CFG_ATU_BIT];
			s_d.cfg_edge = reg_wdata_in[`EAPI_CFG_EDGE_LSB +: 8];
		end
		if (wr_lpri) begin
			s_d.pri_line = reg_wdata_in; // RQ13
		end
		if (wr_pa) begin
			s_d.pri_a = reg_wdata_in[15:0]; // RQ13
		end
		if (wr_pd) begin
			s_d.pri_d = reg_wdata_in[15:0]; // RQ13
		end
		if (wr_mclr) begin
			s_d.mask = s_d.mask & ~reg_wdata_in[7:0];
		end
		if (wr_mset) begin
			s_d.mask = s_d.mask | reg_wdata_in[7:0];
		end

		// request latch: set beats clear in the same cycle
		s_d.latch = line_det | (s_q.latch & ~line_clr); // RQ1 RQ2

		// cpu acceptance
		if (wr_thr) begin
			s_d.thr = reg_wdata_in[3:0];
		end
		if (cpu_accept_in) begin
			// accept racing a flag change may see nothing pending
			s_d.evt = s_q.req ? s_q.code : `EAPI_EVT_NONE; // RQ12 RQ17
			if (s_q.req && s_q.cfg_atu && !s_q.src_irl) begin // RQ4 RQ9
				s_d.thr = s_q.lvl; // RQ4
			end
		end

		// presented request, level and code move together
		s_d.req = best_lvl > s_d.thr; // RQ25
		s_d.lvl = best_lvl; // RQ26
		s_d.code = best_code; // RQ26
		s_d.src_irl = best_irl;

		// read data stands one cycle only
		s_d.rdata = reg_rd_in ? rd_val : 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_q <= '0;
			s_q.pri_line <= `EAPI_RST_PRI32; // RQ13
			s_q.pri_a <= `EAPI_RST_PRI16; // RQ13
			s_q.pri_d <= `EAPI_RST_PRI16; // RQ13
			s_q.mask <= `EAPI_RST_MASK;
			s_q.evt <= `EAPI_RST_EVT;
			s_q.thr <= `EAPI_RST_THR;
			s_q.il_s1 <= `EAPI_RST_IRL_B;
			s_q.il_s2 <= `EAPI_RST_IRL_B;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_out = s_q.rdata;
	assign irq_req_out = s_q.req;
	assign irq_level_out = s_q.lvl;
	assign irq_code_out = s_q.code;
	assign interrupt_event_code_reg_out = s_q.evt;
	assign cpu_level_threshold_out = s_q.thr;
endmodule

// [shared/eapi_flt_if.sv]
/*
 * link between the prioritizer and its encoded-level noise canceller.
 * assumes both ends share one clock.
 */
`timescale 1ns/100ps

interface eapi_flt_if;
	logic [3:0] raw_b;
	logic sample;
	logic [3:0] level;

	modport host (output raw_b, output sample, input level);
	modport filt (input raw_b, input sample, output level);
endinterface

// [shared/eapi_map.svh]
/*
 * register offsets, reset values, field positions and event codes of
 * the interrupt source prioritizer.
 * assumes a word-addressed register port with byte offsets below.
 */
`ifndef EAPI_MAP_SVH
`define EAPI_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EAPI_OFS_CONFIG 8'h00
`define EAPI_OFS_LINE_PRI 8'h04
`define EAPI_OFS_PRI_A 8'h08
`define EAPI_OFS_PRI_D 8'h0C
`define EAPI_OFS_REQ_LATCH 8'h10
`define EAPI_OFS_MASK_SET 8'h14
`define EAPI_OFS_MASK_CLR 8'h18
`define EAPI_OFS_EVT_CODE 8'h1C
`define EAPI_OFS_THRESHOLD 8'h20

// ----------------------------------------------------------------
// config fields
// ----------------------------------------------------------------
`define EAPI_CFG_LHO_BIT 0
`define EAPI_CFG_ATU_BIT 1
`define EAPI_CFG_EDGE_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EAPI_RST_PRI32 32'h0000_0000
`define EAPI_RST_PRI16 16'h0000
`define EAPI_RST_MASK 8'h00
`define EAPI_RST_EVT 12'h000
`define EAPI_RST_THR 4'h0
`define EAPI_RST_IRL_B 4'hF

// ----------------------------------------------------------------
// priority fields within priority_reg_a, priority_reg_d and the line priority register
// ----------------------------------------------------------------
`define EAPI_PRA_TMR0_MSB 15
`define EAPI_PRA_TMR1_MSB 11
`define EAPI_PRA_TMR2_MSB 7
`define EAPI_PRA_RTC_MSB 3
`define EAPI_PRD_PINA_MSB 15
`define EAPI_PRD_PINB_MSB 11
`define EAPI_LINE_PRI_MSB 31

// ----------------------------------------------------------------
// event codes
// ----------------------------------------------------------------
`define EAPI_EVT_NONE 12'h000
`define EAPI_EVT_STEP 12'h020
`define EAPI_EVT_IRL_BASE 12'h200
`define EAPI_EVT_LINE_BASE 12'h600
`define EAPI_EVT_TMR0 12'h400
`define EAPI_EVT_TMR1 12'h420
`define EAPI_EVT_TMR2 12'h440
`define EAPI_EVT_RTC_ALM 12'h480
`define EAPI_EVT_RTC_PER 12'h4A0
`define EAPI_EVT_RTC_CRY 12'h4C0
`define EAPI_EVT_PINA 12'h4E0
`define EAPI_EVT_PINB 12'h500

`endif

// [shared/eapi_pkg.sv]
/*
 * types of the interrupt source prioritizer.
 * assumes nothing beyond a systemverilog compiler.
 */
package eapi_pkg;

	typedef logic [3:0] eapi_lvl_t;
	typedef logic [11:0] eapi_code_t;

	// noise canceller state
	typedef struct packed {
		logic [3:0] prev_b;
		eapi_lvl_t lvl;
	} eapi_flt_s;

	// state of the prioritizer outside its noise canceller
	typedef struct packed {
		logic [7:0] ln_s1;
		logic [7:0] ln_s2;
		logic [7:0] ln_s3;
		logic [7:0] pa_s1;
		logic [7:0] pa_s2;
		logic [3:0] pb_s1;
		logic [3:0] pb_s2;
		logic [3:0] il_s1;
		logic [3:0] il_s2;
		logic tk_s1;
		logic tk_s2;
		logic tk_s3;
		logic cfg_lho;
		logic cfg_atu;
		logic [7:0] cfg_edge;
		logic [31:0] pri_line;
		logic [15:0] pri_a;
		logic [15:0] pri_d;
		logic [7:0] latch;
		logic [7:0] mask;
		eapi_code_t evt;
		eapi_lvl_t thr;
		logic req;
		eapi_lvl_t lvl;
		eapi_code_t code;
		logic src_irl;
		logic [31:0] rdata;
	} eapi_state_s;

endpackage

// [tb/eapi_asserts.sv]
/* concurrent checks on the prioritizer ports.
   assumes it is bound into eapi_top and sees its ports only. */
`timescale 1ns/100ps
`include "eapi_map.svh"

module eapi_asserts #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// watched inputs
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [3:0] encoded_level_inputs_b_in,
	input wire logic standby_in,
	input wire logic cpu_accept_in,
	// watched outputs
	input wire logic irq_req_out,
	input wire eapi_pkg::eapi_lvl_t irq_level_out,
	input wire eapi_pkg::eapi_code_t irq_code_out,
	input wire eapi_pkg::eapi_code_t interrupt_event_code_reg_out,
	input wire eapi_pkg::eapi_lvl_t cpu_level_threshold_out
);
	import eapi_pkg::*;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_taken;
		cpu_accept_in && irq_req_out;
	endsequence
	sequence s_irl_max;
		(encoded_level_inputs_b_in == 4'h0 && !standby_in) [*8];
	endsequence
	// a one-cycle glitch between long idle stretches
	sequence s_blip;
		(encoded_level_inputs_b_in == 4'hF && !standby_in) [*5]
		##1 (encoded_level_inputs_b_in != 4'hF && !standby_in)
		##1 (encoded_level_inputs_b_in == 4'hF && !standby_in) [*6];
	endsequence

	a_accept_code:
	assert property (s_taken |=> interrupt_event_code_reg_out ==
		$past(irq_code_out)) else $error("code not captured on accept");
	a_idle_accept:
	assert property (cpu_accept_in && !irq_req_out |=>
		interrupt_event_code_reg_out == 12'h000)
		else $error("idle accept code not zero");
	a_code_hold:
	assert property (!cpu_accept_in |=>
		$stable(interrupt_event_code_reg_out))
		else $error("event code changed without accept");
	a_thr_hold:
	assert property (!cpu_accept_in && !(reg_wr_in &&
		reg_addr_in == `EAPI_OFS_THRESHOLD) |=>
		$stable(cpu_level_threshold_out)) else $error("threshold moved");
	a_req_above:
	assert property (irq_req_out ==
		(irq_level_out > cpu_level_threshold_out))
		else $error("request not level above threshold");
	a_code_none:
	assert property ((irq_level_out == 4'h0) == (irq_code_out == 12'h000))
		else $error("level and code disagree");
	a_irl_level:
	assert property (irq_code_out[11:9] == 3'b001 |->
		irq_level_out == 4'hF - irq_code_out[8:5])
		else $error("encoded level code and level disagree");
	a_irl_max:
	assert property (s_irl_max |-> irq_code_out == 12'h200 &&
		irq_level_out == 4'hF) else $error("all zeros not top level");
	a_irl_blip:
	assert property (s_blip |-> irq_code_out[11:9] != 3'b001)
		else $error("single sample glitch recognised");
endmodule

bind eapi_top eapi_asserts #(.ADDR_W(ADDR_W)) eapi_asserts_inst (
	.clock_in, .rst_b_in, .reg_addr_in, .reg_wr_in,
	.encoded_level_inputs_b_in, .standby_in, .cpu_accept_in,
	.irq_req_out, .irq_level_out, .irq_code_out,
	.interrupt_event_code_reg_out, .cpu_level_threshold_out
);

// [tb/eapi_cpu_model.sv]
/* cpu core model: takes one interrupt at a boundary per arming.
   assumes arm_in is a one-cycle pulse from the bench, same clock. */
`timescale 1ns/100ps

module eapi_cpu_model (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// bench control
	input wire logic arm_in,
	input wire logic any_in,
	input wire logic slow_in,
	// prioritizer side
	input wire logic irq_req_in,
	output logic accept_out
);
	logic armed_q;
	logic [1:0] wait_q;

	// one accept per arming: the gate stays shut until the bench has
	// cleared what it must and arms again
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			armed_q <= 1'b0;
			wait_q <= 2'h0;
			accept_out <= 1'b0;
		end else begin
			accept_out <= 1'b0;
			if (arm_in) begin
				armed_q <= 1'b1;
				wait_q <= slow_in ? 2'h3 : 2'h0;
			end else if (armed_q && (irq_req_in || any_in)) begin
				if (wait_q != 2'h0) begin
					wait_q <= wait_q - 2'h1;
				end else begin
					accept_out <= 1'b1;
					armed_q <= 1'b0;
				end
			end
		end
	end
endmodule

// [tb/tb_eapi_top.sv]
/* self-checking bench of the prioritizer with a cpu model.
   assumes eapi_top, eapi_cpu_model and the bound checker. */
`timescale 1ns/100ps
`include "eapi_map.svh"

module tb_eapi_top;
	import eapi_pkg::*;
	logic clock_in, rst_b_in, reg_wr_in, reg_rd_in, standby_in;
	logic [7:0] reg_addr_in, ext_line_in, src, pa_bits;
	logic [31:0] reg_wdata_in, reg_rdata_out, seed, lp;
	logic [3:0] enc_b, pb_bits;
	logic rtc_tick_in, rtc_run, cpu_accept_in, irq_req_out, arm, any, slow;
	eapi_lvl_t irq_level_out, cpu_level_threshold_out;
	eapi_code_t irq_code_out, interrupt_event_code_reg_out;
	logic [15:0] pa, pd;
	int fails, checked;

	eapi_top eapi_top_inst (.clock_in, .rst_b_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.ext_line_in, .encoded_level_inputs_b_in(enc_b),
		.pin_group_a_inputs_in(src[6] ? pa_bits : 8'h00),
		.pin_group_b_inputs_in(src[7] ? pb_bits : 4'h0),
		.timer_underflow_in(src[2:0]), .rtc_alarm_source_in(src[3]),
		.rtc_periodic_source_in(src[4]), .rtc_carry_source_in(src[5]),
		.standby_in, .rtc_tick_in, .cpu_accept_in, .irq_req_out,
		.irq_level_out, .irq_code_out, .interrupt_event_code_reg_out,
		.cpu_level_threshold_out);
	eapi_cpu_model eapi_cpu_model_inst (.clock_in, .rst_b_in, .arm_in(arm),
		.any_in(any), .slow_in(slow), .irq_req_in(irq_req_out),
		.accept_out(cpu_accept_in));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [3:0] rnib();
		seed = lfsr(seed);
		return (seed[3:0] == 4'h0) ? 4'h1 : seed[3:0];
	endfunction
	function automatic eapi_code_t src_code(input int i);
		eapi_code_t t[8] = '{12'h400, 12'h420, 12'h440, 12'h480,
			12'h4A0, 12'h4C0, 12'h4E0, 12'h500};
		return t[i];
	endfunction
	function automatic eapi_lvl_t src_lvl(input int i);
		if (i < 3) return pa[15 - 4 * i -: 4];
		if (i < 6) return pa[3:0];
		return (i == 6) ? pd[15:12] : pd[11:8];
	endfunction

	task automatic chk(input logic [31:0] seen, exp, input string what);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, e, "read data");
	endtask
	task automatic take(input logic a, input logic s);
		int n;
		@(posedge clock_in);
		any <= a;
		slow <= s;
		arm <= 1'b1;
		@(posedge clock_in);
		arm <= 1'b0;
		#1 n = 0;
		while (cpu_accept_in !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		chk(n < 50, 1, "accept");
		cyc(1);
	endtask
	task automatic end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	// rtc clock, unrelated in phase, gated to model its absence
	initial begin
		rtc_tick_in = 1'b0;
		forever #37 if (rtc_run) rtc_tick_in = ~rtc_tick_in;
	end
	initial begin
		#100000 fails++;
		end_of_test();
	end

	initial begin
		{rst_b_in, reg_wr_in, reg_rd_in, standby_in, arm, any, slow} = 0;
		{reg_addr_in, ext_line_in, src, reg_wdata_in, rtc_run} = 0;
		{fails, checked} = 0;
		enc_b = 4'hF;
		seed = 32'h0000_0ce3;
		pa_bits = {rnib(), rnib()};
		pb_bits = rnib();
		repeat (5) @(posedge clock_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 10; i++) rd((i == 9) ? 8'h3C : 8'(4 * i), 0);
		src <= 8'hFF;
		cyc(6);
		chk(irq_level_out, 0, "masked level");
		pa = {rnib(), rnib(), rnib(), rnib()};
		pd = {rnib(), rnib(), 8'h00};
		wr(`EAPI_OFS_PRI_A, pa);
		wr(`EAPI_OFS_PRI_D, pd);
		rd(`EAPI_OFS_PRI_D, pd);
		for (int i = 0; i < 8; i++) begin
			src <= 8'h01 << i;
			cyc(6);
			chk(irq_code_out, src_code(i), "source code");
			chk(irq_level_out, src_lvl(i), "source level");
		end
		wr(`EAPI_OFS_PRI_A, 16'h5555);
		for (int i = 0; i < 6; i++) begin
			src <= (8'h3F << i) & 8'h3F;
			cyc(6);
			chk(irq_code_out, src_code(i), "tie order");
		end
		src <= 8'h00;
		wr(`EAPI_OFS_CONFIG, 1);
		for (int i = 0; i < 8; i++) lp = {lp[27:0], rnib()};
		wr(`EAPI_OFS_LINE_PRI, lp);
		for (int i = 0; i < 8; i++) begin
			ext_line_in <= 8'h01 << i;
			cyc(6);
			chk(irq_code_out, 12'h600 + 12'h020 * i, "line code");
			chk(irq_level_out, lp[31 - 4 * i -: 4], "line level");
		end
		ext_line_in <= 8'h00;
		cyc(6);
		chk(irq_level_out, 0, "unheld line");
		// line 4 on rising edge with hold off: the pulse must still latch
		wr(`EAPI_OFS_CONFIG, 32'h0000_1001);
		ext_line_in <= 8'h10;
		cyc(3);
		ext_line_in <= 8'h00;
		cyc(6);
		chk(irq_code_out, 12'h680, "edge line");
		take(0, 0);
		chk(interrupt_event_code_reg_out, 12'h680, "edge evt");
		rd(`EAPI_OFS_REQ_LATCH, 0);
		wr(`EAPI_OFS_CONFIG, 0);
		for (int m = 0; m < 2; m++) begin
			ext_line_in <= 8'h08;
			cyc(3);
			ext_line_in <= 8'h00;
			cyc(6);
			chk(irq_code_out, 12'h660, "held line");
			rd(`EAPI_OFS_REQ_LATCH, 8);
			if (m == 0) take(0, 1);
			else wr(`EAPI_OFS_MASK_SET, 8);
			if (m == 0) chk(interrupt_event_code_reg_out, 12'h660, "evt");
			rd(`EAPI_OFS_REQ_LATCH, 0);
		end
		wr(`EAPI_OFS_MASK_CLR, 8);
		rd(`EAPI_OFS_MASK_SET, 0);
		for (int k = 0; k < 15; k++) begin
			enc_b <= 4'(k);
			cyc(8);
			chk(irq_code_out, 12'h200 + 12'h020 * k, "irl code");
			chk(irq_level_out, 4'hF - 4'(k), "irl level");
		end
		enc_b <= 4'hF;
		cyc(8);
		enc_b <= 4'h5;
		cyc(1);
		enc_b <= 4'hF;
		cyc(8);
		chk(irq_level_out, 0, "glitch");
		standby_in <= 1'b1;
		enc_b <= 4'h3;
		cyc(20);
		chk(irq_level_out, 0, "standby no rtc");
		rtc_run = 1'b1;
		cyc(80);
		chk(irq_code_out, 12'h260, "standby rtc");
		rtc_run = 1'b0;
		standby_in <= 1'b0;
		enc_b <= 4'hF;
		wr(`EAPI_OFS_CONFIG, 2);
		wr(`EAPI_OFS_PRI_A, 16'h9000);
		src <= 8'h01;
		cyc(6);
		take(0, 0);
		chk(cpu_level_threshold_out, 9, "auto threshold");
		chk(irq_req_out, 0, "request at threshold");
		wr(`EAPI_OFS_THRESHOLD, 0);
		enc_b <= 4'h3;
		cyc(8);
		take(0, 0);
		chk(cpu_level_threshold_out, 0, "irl threshold");
		chk(interrupt_event_code_reg_out, 12'h260, "irl evt");
		wr(`EAPI_OFS_CONFIG, 0);
		enc_b <= 4'hF;
		cyc(8);
		take(0, 1);
		chk(cpu_level_threshold_out, 0, "fixed threshold");
		src <= 8'h40;
		cyc(6);
		take(0, 0);
		chk(interrupt_event_code_reg_out, 12'h4E0, "pin evt");
		src <= 8'h00;
		cyc(8);
		take(1, 0);
		chk(interrupt_event_code_reg_out, 0, "idle evt");
		end_of_test();
	end
endmodule
